//--- ncde_pkg.sv
// Shared constants, state type and decode helpers for the nibble core
package ncde_pkg;

    // Datapath widths
    localparam int PC_W = 9;
    localparam int NIB_W = 4;
    localparam int PTR_W = 6;
    localparam int RAM_WORDS = 64;

    // Instruction cycle timing: 16 us at an 8 ns system clock
    localparam int INSTR_CYCLE_NS = 16000;
    localparam int SYS_CLK_NS = 8;
    localparam int CYCLE_CLKS = INSTR_CYCLE_NS / SYS_CLK_NS;
    localparam int MIN_CYCLE_CLKS = 4;

    // Reset values
    localparam logic [PC_W-1:0] RESET_PC = 9'h000;
    localparam logic [NIB_W-1:0] RESET_NIB = 4'h0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Single-byte opcodes
    localparam logic [7:0] OP_CLEAR_ACC = 8'h00;
    localparam logic [7:0] OP_PREFIX = 8'h33;
    localparam logic [7:0] OP_TEST_CARRY = 8'h20;
    localparam logic [7:0] OP_TEST_EQUAL = 8'h21;
    localparam logic [7:0] OP_SWAP_SERIAL = 8'h4F;
    localparam logic [7:0] OP_IND_JUMP = 8'hFF;
    localparam logic [7:0] OP_TABLE_LOAD = 8'hBF;

    // Second bytes after the prefix
    localparam logic [7:0] OP2_PORT_ZERO = 8'h21;
    localparam logic [7:0] OP2_READ_LED = 8'h2E;
    localparam logic [7:0] OP2_READ_GEN = 8'h2A;
    localparam logic [7:0] OP2_WRITE_DIGIT = 8'h3E;
    localparam logic [7:0] OP2_WRITE_GEN = 8'h3A;
    localparam logic [3:0] OP2_SELECT_HI = 4'h6;

    // Two-byte long jump group and subroutine page
    localparam logic [3:0] OP_LONG_HI = 4'h6;
    localparam logic [2:0] SUB_PAGE = 3'b010;
    localparam logic [1:0] SUB_REGION = 2'b01;

    typedef enum {ST_FETCH, ST_SECOND, ST_INDIRECT} ncde_state_t;

    // Bit tests use 01, 11, 03, 13 for bits 0..3
    function automatic logic is_bit_test(input logic [7:0] op);
        return (op[7:5] == 3'b000) && (op[3:2] == 2'b00) && op[0];
    endfunction

    function automatic logic [1:0] bit_index(input logic [7:0] op);
        return {op[1], op[4]};
    endfunction

    // Immediate pointer load: 00 r 1xxx (digit 0 or 9..15)
    function automatic logic is_ptr_load(input logic [7:0] op);
        return (op[7:6] == 2'b00) && op[3];
    endfunction

    // Field holds digit minus one, so 1111 wraps to digit 0
    function automatic logic [NIB_W-1:0] ptr_load_digit(input logic [7:0] op);
        return NIB_W'(op[3:0] + 4'h1);
    endfunction

    function automatic logic is_two_byte(input logic [7:0] op);
        return (op == OP_PREFIX) ||
               ((op[7:4] == OP_LONG_HI) && (op[2:1] == 2'b00));
    endfunction

endpackage

//--- ncde_cycle_timer.sv
// Instruction cycle divider: address, data and execute strobes
`timescale 1ns/1ps
`default_nettype none

module ncde_cycle_timer #(
    parameter int CYCLE_CLKS = ncde_pkg::CYCLE_CLKS
) (
    input wire logic sys_clk,
    input wire logic reset,
    output logic addr_start,
    output logic data_start,
    output logic exec_strobe
);
    import ncde_pkg::*;

    localparam int CNT_W = $clog2(CYCLE_CLKS);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLE_CLKS - 1);
    localparam logic [CNT_W-1:0] HALF = CNT_W'(CYCLE_CLKS / 2);

    // Elaboration check: fewer clocks would merge the strobes
    if (CYCLE_CLKS < MIN_CYCLE_CLKS) begin : g_cycle_check
        $error("cycle must span at least four clocks");
    end

    logic [CNT_W-1:0] count;

    // Free-running count over one instruction cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
        end else begin
            count <= CNT_W'(count + 1'b1);
        end
    end

    // Strobes are registered so each is exactly one clock wide
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            addr_start <= 1'b0;
            data_start <= 1'b0;
            exec_strobe <= 1'b0;
        end else begin
            addr_start <= (count == '0);
            data_start <= (count == HALF);
            exec_strobe <= (count == LAST);
        end
    end

endmodule
`default_nettype wire

//--- ncde_skip_eval.sv
// Skip condition evaluation for the test instructions
`timescale 1ns/1ps
`default_nettype none

module ncde_skip_eval (
    input wire logic [7:0] op,
    input wire logic prefixed,
    input wire logic [3:0] acc,
    input wire logic [3:0] mem,
    input wire logic carry_flag,
    input wire logic [3:0] gen_in,
    output logic skip_hit
);
    import ncde_pkg::*;

    // Prefixed tests look at the port, plain ones at carry and memory
    always_comb begin
        skip_hit = 1'b0;
        if (prefixed) begin
            if (op == OP2_PORT_ZERO) begin
                skip_hit = (gen_in == 4'h0);
            end else if (is_bit_test(op)) begin
                skip_hit = !gen_in[bit_index(op)];
            end
        end else begin
            if (op == OP_TEST_CARRY) begin
                skip_hit = carry_flag;
            end else if (op == OP_TEST_EQUAL) begin
                skip_hit = (acc == mem);
            end else if (is_bit_test(op)) begin
                skip_hit = !mem[bit_index(op)];
            end
        end
    end

endmodule
`default_nettype wire

//--- ncde_core.sv
// Decode and execute core for the nibble controller with external ROM
//
// Summary of operation
// - Pointer load byte sets row and digit
// - Digit field is value minus one, wraps
// - Following pointer loads skipped until another opcode
// - Prefixed 6y copies y into select latch
// - 20 skips on carry, 21 on equal
// - Prefixed 21 skips when port reads zero
// - Prefixed bit test skips on zero port bit
// - Plain bit test skips on zero memory bit
// - Read LED port to memory/acc; port to acc
// - Digit pointer to digit port; memory to port
// - 4F swaps acc with serial, carry to clock
// - FF loads low counter bits from ROM indirectly
// - Table load fetches indirect byte into output latch
// - Table load copies level one into level two
// - Skipped bytes each still cost one cycle
// - Indirect ops two cycles, one when skipped
// - Nine-bit counter runs across page boundaries
// - Last-word paging ops act from next page
// - In-page jump spans page or pages two-three
// - Subroutine page call loads page two
// - Pointer is two row bits, four digit
// - Serial register is four bits wide
`timescale 1ns/1ps
`default_nettype none

module ncde_core #(
    parameter int CYCLE_CLKS = ncde_pkg::CYCLE_CLKS
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic carry_flag,
    input wire logic [3:0] gen_port_in,
    input wire logic [7:0] led_port_in,
    input wire logic [7:0] program_bus_pins_in,
    output logic [7:0] program_bus_pins_out,
    output logic program_bus_pins_oe,
    output logic program_address_msb,
    output logic addr_data_flag,
    output logic skip_out,
    output logic [3:0] digit_outputs,
    output logic [3:0] general_port_out,
    output logic [7:0] lookup_latch,
    output logic [3:0] select_latch,
    output logic clock_output_latch,
    output logic [3:0] accumulator,
    output logic [3:0] serial_shift_counter
);
    import ncde_pkg::*;

    // Refuse cycle lengths that leave no room for both bus halves;
    // the address and data strobes would otherwise coincide
    if (CYCLE_CLKS < MIN_CYCLE_CLKS) begin : g_cycle_check
        $error("cycle length too short for the bus phases");
    end

    ncde_state_t state;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack_level_one;
    logic [PC_W-1:0] stack_level_two;
    logic [1:0] row_pointer;
    logic [3:0] digit_pointer;
    logic skip;
    logic chain_skip;
    logic second_skip;
    logic ind_is_jump;
    logic [7:0] ind_low;
    logic [7:0] first_op;
    logic [NIB_W-1:0] ram [RAM_WORDS];

    logic addr_start;
    logic data_start;
    logic exec;
    logic skip_hit;
    logic [7:0] op;
    logic [NIB_W-1:0] mem;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] fetch_addr;
    logic run_first;
    logic run_second;
    logic run_prefixed;

    ncde_cycle_timer #(
        .CYCLE_CLKS(CYCLE_CLKS)
    ) u_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .addr_start(addr_start),
        .data_start(data_start),
        .exec_strobe(exec)
    );

    ncde_skip_eval u_skip (
        .op(op),
        .prefixed(state == ST_SECOND),
        .acc(accumulator),
        .mem(mem),
        .carry_flag(carry_flag),
        .gen_in(gen_port_in),
        .skip_hit(skip_hit)
    );

    // Fetched byte, addressed nibble and qualified execute conditions
    assign op = program_bus_pins_in;
    assign mem = ram[{row_pointer, digit_pointer}];
    assign pc_inc = PC_W'(pc + 1'b1);
    assign run_first = (state == ST_FETCH) && !skip &&
                       !(chain_skip && is_ptr_load(op));
    assign run_second = (state == ST_SECOND) && !second_skip;
    assign run_prefixed = run_second && (first_op == OP_PREFIX);

    // Indirect cycle reads through the latched {page msb, acc, mem}
    assign fetch_addr = (state == ST_INDIRECT) ? {pc[8], ind_low} : pc;

    // Multiplexed bus: address half first, then bus released for data
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            program_bus_pins_out <= RESET_BYTE;
            program_bus_pins_oe <= 1'b0;
            program_address_msb <= 1'b0;
            addr_data_flag <= 1'b0;
            skip_out <= 1'b0;
        end else if (addr_start) begin
            program_bus_pins_out <= fetch_addr[7:0];
            program_address_msb <= fetch_addr[8];
            program_bus_pins_oe <= 1'b1;
            addr_data_flag <= 1'b1;
            skip_out <= ((state == ST_FETCH) && skip) ||
                        ((state == ST_SECOND) && second_skip);
        end else if (data_start) begin
            program_bus_pins_oe <= 1'b0;
            addr_data_flag <= 1'b0;
        end
    end

    // Sequencer: counter, stack, skip flags and cycle state
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= ST_FETCH;
            pc <= RESET_PC;
            stack_level_one <= RESET_PC;
            stack_level_two <= RESET_PC;
            skip <= 1'b0;
            chain_skip <= 1'b0;
            second_skip <= 1'b0;
            ind_is_jump <= 1'b0;
            ind_low <= RESET_BYTE;
            first_op <= RESET_BYTE;
        end else if (exec) begin
            unique case (state)
                ST_FETCH: begin
                    pc <= pc_inc;
                    first_op <= op;
                    if (!run_first) begin
                        // Skipped byte still burns its own cycle
                        skip <= 1'b0;
                        chain_skip <= chain_skip && is_ptr_load(op);
                        if (is_two_byte(op)) begin
                            state <= ST_SECOND;
                            second_skip <= 1'b1;
                        end
                    end else begin
                        chain_skip <= is_ptr_load(op);
                        skip <= skip_hit;
                        if (is_two_byte(op)) begin
                            state <= ST_SECOND;
                            second_skip <= 1'b0;
                        end else if (op == OP_IND_JUMP ||
                                     op == OP_TABLE_LOAD) begin
                            // Second cycle only when executed
                            state <= ST_INDIRECT;
                            ind_is_jump <= (op == OP_IND_JUMP);
                            ind_low <= {accumulator, mem};
                        end else if (op[7] && pc_inc[8:7] == SUB_REGION) begin
                            // Pages two and three share one jump region
                            pc <= {pc_inc[8:7], op[6:0]};
                        end else if (op[7:6] == 2'b11) begin
                            pc <= {pc_inc[8:6], op[5:0]};
                        end else if (op[7:6] == 2'b10) begin
                            stack_level_two <= stack_level_one;
                            stack_level_one <= pc_inc;
                            pc <= {SUB_PAGE, op[5:0]};
                        end
                    end
                end
                ST_SECOND: begin
                    // Long jumps are not decoded anywhere; second byte still runs the prefixed skip tests
                    pc <= pc_inc;
                    state <= ST_FETCH;
                    second_skip <= 1'b0;
                    if (run_second) begin
                        skip <= skip_hit;
                    end
                end
                ST_INDIRECT: begin
                    state <= ST_FETCH;
                    if (ind_is_jump) begin
                        // Page msb taken from the incremented counter
                        pc[7:0] <= op;
                    end else begin
                        // Push then pop leaves level one in level two
                        stack_level_two <= stack_level_one;
                    end
                end
            endcase
        end
    end

    // RAM pointer
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            row_pointer <= 2'b00;
            digit_pointer <= RESET_NIB;
        end else if (exec && run_first && is_ptr_load(op)) begin
            row_pointer <= op[5:4];
            digit_pointer <= ptr_load_digit(op);
        end
    end

    // Accumulator, serial register and clock latch
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            accumulator <= RESET_NIB;
            serial_shift_counter <= RESET_NIB;
            clock_output_latch <= 1'b0;
        end else if (exec && run_first && op == OP_SWAP_SERIAL) begin
            // Shift timing is left to the program's swap cadence
            accumulator <= serial_shift_counter;
            serial_shift_counter <= accumulator;
            clock_output_latch <= carry_flag;
        end else if (exec && run_first && op == OP_CLEAR_ACC) begin
            accumulator <= RESET_NIB;
        end else if (exec && run_prefixed && op == OP2_READ_LED) begin
            accumulator <= led_port_in[3:0];
        end else if (exec && run_prefixed && op == OP2_READ_GEN) begin
            accumulator <= gen_port_in;
        end
    end

    // Data memory write from the upper LED port nibble
    always_ff @(posedge sys_clk) begin
        if (exec && run_prefixed && op == OP2_READ_LED) begin
            ram[{row_pointer, digit_pointer}] <= led_port_in[7:4];
        end
    end

    // Output latches
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            digit_outputs <= RESET_NIB;
            general_port_out <= RESET_NIB;
            select_latch <= RESET_NIB;
            lookup_latch <= RESET_BYTE;
        end else if (exec) begin
            if (run_prefixed && op == OP2_WRITE_DIGIT) begin
                digit_outputs <= digit_pointer;
            end
            if (run_prefixed && op == OP2_WRITE_GEN) begin
                general_port_out <= mem;
            end
            if (run_prefixed && op[7:4] == OP2_SELECT_HI) begin
                select_latch <= op[3:0];
            end
            if (state == ST_INDIRECT && !ind_is_jump) begin
                lookup_latch <= op;
            end
        end
    end

    // Checks on the execute strobe
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_run(logic [7:0] code);
        exec && run_first && op == code;
    endsequence

    sequence s_second(logic [7:0] code);
        exec && run_prefixed && op == code;
    endsequence

    a_ptr_load_fields: assert property (
        exec && run_first && is_ptr_load(op) |=>
        row_pointer == $past(op[5:4]) &&
        digit_pointer == 4'($past(op[3:0]) + 4'h1))
        else $error("pointer load wrote wrong row or digit");

    a_ptr_chain_skip: assert property (
        exec && state == ST_FETCH && chain_skip && is_ptr_load(op) |=>
        $stable(digit_pointer) && $stable(row_pointer) && chain_skip)
        else $error("chained pointer load was not skipped");

    a_select_load: assert property (
        exec && run_prefixed && op[7:4] == OP2_SELECT_HI |=>
        select_latch == $past(op[3:0]))
        else $error("select latch not loaded");

    a_carry_skip: assert property (
        s_run(OP_TEST_CARRY) |=> skip == $past(carry_flag))
        else $error("carry test skip wrong");

    a_port_zero: assert property (
        s_second(OP2_PORT_ZERO) |=> skip == ($past(gen_port_in) == 4'h0))
        else $error("port zero test skip wrong");

    a_swap_serial: assert property (
        s_run(OP_SWAP_SERIAL) |=>
        accumulator == $past(serial_shift_counter) &&
        serial_shift_counter == $past(accumulator) &&
        clock_output_latch == $past(carry_flag))
        else $error("serial swap wrong");

    a_jump_indirect: assert property (
        exec && state == ST_INDIRECT && ind_is_jump |=>
        pc[7:0] == $past(op) && pc[8] == $past(pc[8]) && state == ST_FETCH)
        else $error("indirect jump target wrong");

    a_lookup_stack: assert property (
        exec && state == ST_INDIRECT && !ind_is_jump |=>
        lookup_latch == $past(op) && stack_level_two == $past(stack_level_one)
        && pc == $past(pc))
        else $error("table load latch or stack wrong");

    a_skip_one_byte: assert property (
        exec && state == ST_FETCH && skip && !is_two_byte(op) |=>
        state == ST_FETCH && !skip && pc == $past(pc_inc))
        else $error("skipped byte took wrong path");

    a_page_call: assert property (
        exec && run_first && op[7:6] == 2'b10 && op != OP_TABLE_LOAD &&
        pc_inc[8:7] != SUB_REGION |=>
        pc[8:6] == SUB_PAGE && stack_level_one == $past(pc_inc))
        else $error("subroutine page call wrong");

endmodule
`default_nettype wire

//--- ncde_rom_model.sv
// External program memory with a clocked address latch
`timescale 1ns/1ps
`default_nettype none

module ncde_rom_model (
    input wire logic sys_clk,
    input wire logic [7:0] addr_lo,
    input wire logic addr_msb,
    input wire logic addr_oe,
    input wire logic addr_data_flag,
    output logic [7:0] rom_data,
    output logic rom_oe
);
    logic [7:0] mem [0:511];
    logic [8:0] addr_latch = 9'h000;

    // Latch follows the bus only while the core flags the address half
    always_ff @(posedge sys_clk) begin
        if (addr_data_flag && addr_oe) begin
            addr_latch <= {addr_msb, addr_lo};
        end
    end

    // Memory drives only in the data half, so it never fights the core
    assign rom_oe = !addr_data_flag;
    assign rom_data = mem[addr_latch];
endmodule

`default_nettype wire

//--- nibble_cpu_decode_exec_bench.sv
// Self-checking bench running a small program from external memory
`timescale 1ns/1ps
`default_nettype none

module nibble_cpu_decode_exec_bench;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic carry_flag, clock_output_latch, pins_oe, addr_msb, adf, skip_out;
    logic [3:0] gen_port_in, digit_outputs, general_port_out, select_latch;
    logic [3:0] accumulator, serial_shift_counter;
    logic [7:0] led_port_in, pins_out, lookup_latch, rom_data, bus;
    logic [7:0] bus_last = 8'h00;
    logic rom_oe;
    int mismatches = 0;
    int n_tests = 0;
    int clks = 0;
    int t0;
    logic [7:0] prog [0:46] = '{8'h00, 8'h1F, 8'h18, 8'h33, 8'h3E, 8'h0A,
        8'h33, 8'h3E, 8'h33, 8'h2E, 8'h33, 8'h3A, 8'h33, 8'h6C, 8'h21, 8'h33,
        8'h2A, 8'h21, 8'h00, 8'h20, 8'h33, 8'h2E, 8'h11, 8'h33, 8'h2E, 8'h13,
        8'h33, 8'h2E, 8'h01, 8'h00, 8'h33, 8'h11, 8'h33, 8'h2A, 8'h33, 8'h01,
        8'h33, 8'h2A, 8'h33, 8'h21, 8'h00, 8'h33, 8'h2A, 8'h4F, 8'h33, 8'h2A,
        8'hFF};
    // Address and byte pairs for jump targets and lookup tables
    logic [16:0] extra [0:19] = '{17'h05560, 17'h060BF, 17'h06120,
        17'h062FF, 17'h06333, 17'h0642E, 17'h065FF, 17'h0A5FF, 17'h0FFBF,
        17'h1A53C, 17'h100E0, 17'h12085, 17'h08533, 17'h08621, 17'h08733,
        17'h0882A, 17'h08920, 17'h08A33, 17'h08B2A, 17'h08CC0};

    ncde_core #(.CYCLE_CLKS(8)) uut (
        .sys_clk(sys_clk),
        .reset(reset),
        .carry_flag(carry_flag),
        .gen_port_in(gen_port_in),
        .led_port_in(led_port_in),
        .program_bus_pins_in(bus),
        .program_bus_pins_out(pins_out),
        .program_bus_pins_oe(pins_oe),
        .program_address_msb(addr_msb),
        .addr_data_flag(adf),
        .skip_out(skip_out),
        .digit_outputs(digit_outputs),
        .general_port_out(general_port_out),
        .lookup_latch(lookup_latch),
        .select_latch(select_latch),
        .clock_output_latch(clock_output_latch),
        .accumulator(accumulator),
        .serial_shift_counter(serial_shift_counter)
    );

    ncde_rom_model u_rom (
        .sys_clk(sys_clk),
        .addr_lo(pins_out),
        .addr_msb(addr_msb),
        .addr_oe(pins_oe),
        .addr_data_flag(adf),
        .rom_data(rom_data),
        .rom_oe(rom_oe)
    );

    // Undriven bus has no pull-up, so it shows a changing pattern
    assign bus = pins_oe ? pins_out : (rom_oe ? rom_data : ~bus_last);

    always @(posedge sys_clk) begin
        bus_last <= bus;
        clks <= clks + 1;
    end

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic cmp(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits, bounded, for the first clock at which a fetch address shows
    task automatic run_to(input logic [8:0] a);
        int n;
        n = 0;
        while (!(pins_oe === 1'b1 && {addr_msb, pins_out} === a) &&
               n < 400) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        cmp("fetch address", {addr_msb, pins_out}, a);
        cmp("address flag", 9'(adf), 9'h001);
    endtask

    task automatic final_report;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Program runs about 70 cycles of 64 ns; the limit leaves wide margin
    initial begin
        #50000;
        mismatches++;
        final_report();
    end

    initial begin
        carry_flag <= 1'b1;
        gen_port_in <= 4'h5;
        led_port_in <= 8'h5A;
        for (int i = 0; i < 512; i++) begin
            u_rom.mem[i] = 8'h44;
        end
        // Program opens with a clear of the accumulator at word zero
        for (int i = 0; i < 47; i++) begin
            u_rom.mem[i] = prog[i];
        end
        for (int i = 0; i < 20; i++) begin
            u_rom.mem[extra[i][16:8]] = extra[i][7:0];
        end
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        run_to(9'h005);
        cmp("digit", 9'(digit_outputs), 9'h000);
        run_to(9'h008);
        cmp("digit", 9'(digit_outputs), 9'h00B);
        run_to(9'h00A);
        cmp("acc", 9'(accumulator), 9'h00A);
        run_to(9'h00C);
        cmp("general", 9'(general_port_out), 9'h005);
        run_to(9'h00E);
        cmp("select", 9'(select_latch), 9'h00C);
        run_to(9'h00F);
        repeat (4) @(posedge sys_clk);
        #1;
        cmp("skip flag", 9'(skip_out), 9'h000);
        run_to(9'h011);
        cmp("acc", 9'(accumulator), 9'h005);
        run_to(9'h012);
        repeat (4) @(posedge sys_clk);
        #1;
        cmp("skip flag", 9'(skip_out), 9'h001);
        run_to(9'h013);
        cmp("acc", 9'(accumulator), 9'h005);
        t0 = clks;
        run_to(9'h016);
        cmp("acc", 9'(accumulator), 9'h005);
        cmp("skip span", 9'(clks - t0), 9'h018);
        run_to(9'h01C);
        cmp("acc", 9'(accumulator), 9'h005);
        run_to(9'h01E);
        cmp("acc", 9'(accumulator), 9'h000);
        run_to(9'h022);
        cmp("acc", 9'(accumulator), 9'h000);
        run_to(9'h026);
        cmp("acc", 9'(accumulator), 9'h005);
        run_to(9'h029);
        cmp("acc", 9'(accumulator), 9'h000);
        // A single swap here; a shifting program repeats it every 4 cycles
        run_to(9'h02C);
        cmp("acc", 9'(accumulator), 9'h000);
        cmp("serial", 9'(serial_shift_counter), 9'h005);
        cmp("clock latch", 9'(clock_output_latch), 9'h001);
        run_to(9'h02E);
        t0 = clks;
        run_to(9'h060);
        cmp("jump span", 9'(clks - t0), 9'h010);
        t0 = clks;
        run_to(9'h061);
        cmp("lookup", 9'(lookup_latch), 9'h060);
        cmp("lookup span", 9'(clks - t0), 9'h010);
        t0 = clks;
        run_to(9'h063);
        cmp("skipped jump span", 9'(clks - t0), 9'h010);
        run_to(9'h0FF);
        run_to(9'h100);
        cmp("lookup", 9'(lookup_latch), 9'h03C);
        run_to(9'h120);
        // Clear port and carry so the other branch of each test is taken
        @(posedge sys_clk);
        gen_port_in <= 4'h0;
        carry_flag <= 1'b0;
        run_to(9'h085);
        run_to(9'h089);
        cmp("acc", 9'(accumulator), 9'h00A);
        run_to(9'h08C);
        cmp("acc", 9'(accumulator), 9'h000);
        // Jump from page two lands in page three of the shared region
        run_to(9'h0C0);
        final_report();
    end
endmodule

`default_nettype wire
